// [msgq_pkg.sv]
/*
  Shared constants and carrier types of the message priority queue and
  line scroller: queue geometry, priorities, scroll modes, register map,
  tick timing and the packed structs that travel between the ports.
  Assumes a single 20 MHz system clock and a synchronous reset.
*/
// ----------------------------------------------------------------------
// How it works
// RQ1 - each message line owns mode and two times
// RQ2 - static mode keeps characters fixed
// RQ3 - block mode shows blocks for block time
// RQ4 - after last block, blank one block time
// RQ5 - over-wide block cut to display width
// RQ6 - character mode shifts left per interval
// RQ7 - text re-enters from right after leaving
// RQ8 - segmented character mode scrolls blocks separately
// RQ9 - unconfigured priority defaults to one
// RQ10 - priority 1..255, smaller is more important
// RQ11 - equal or better replaces, else dropped/queued
// RQ12 - queue grouped by priority, LIFO per group
// RQ13 - on cancel with nothing pending, show entry 0
// RQ14 - queue holds 32 entries, 0 is top
// RQ15 - queue off: temporary entry for shown only
// RQ16 - queue on: every display message gets entry; code gives none to one without queue_flag that does not take the display
// RQ17 - non-queued entry deleted when leaving display
// RQ18 - non-display destinations execute, never queue
// RQ19 - cancel deletes entry, lower entries move up
// RQ20 - timeout runs only while shown, kept
// RQ21 - expiry cancels message; off never expires
// RQ22 - full queue drops bottom or refuses newcomer
// ----------------------------------------------------------------------
package msgq_pkg;

  // queue geometry and priorities
  localparam int unsigned QDEPTH      = 32;
  localparam logic [5:0]  QDEPTH_CNT  = 6'h20;
  localparam logic [7:0]  PRI_DEFAULT = 8'h01;
  localparam logic [7:0]  PRI_NONE    = 8'h00;
  localparam logic [8:0]  DISP_W      = 9'h014;  // characters per line

  // tick that paces timeouts and scrolling
  localparam int unsigned TICK_US     = 10000;
  localparam int unsigned CLK_MHZ     = 20;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int unsigned TICK_CNT_W  = 18;

  // register map
  localparam logic [3:0]  REG_CTRL    = 4'h0;
  localparam logic [3:0]  REG_STATUS  = 4'h4;
  localparam logic [3:0]  REG_SHOWN   = 4'h8;
  localparam int unsigned CTRL_QEN    = 0;
  localparam logic        QEN_RST     = 1'b1;

  typedef enum logic [1:0] {
    SCR_STATIC = 2'h0,
    SCR_BLOCK  = 2'h1,
    SCR_CHAR   = 2'h3
  } scroll_mode_t;

  typedef struct packed {
    scroll_mode_t mode;
    logic [7:0]   blk_time;   // ticks per block
    logic [7:0]   chr_time;   // ticks per character step
  } line_cfg_t;

  typedef struct packed {
    logic [7:0]      id;
    logic [7:0]      pri;
    logic            to_disp;
    logic            to_mirror;  // remote_mirror_display
    logic            to_xmit;
    logic            to_cmd;
    logic            queue_flag;
    logic            tmo_on;
    logic [15:0]     tmo;        // ticks
    line_cfg_t [1:0] cfg;        // [0] top, [1] bottom
  } msg_req_t;

  typedef struct packed {
    logic [7:0]      id;
    logic [7:0]      pri;
    logic            queue_flag;
    logic            tmo_on;
    logic [15:0]     tmo;
    line_cfg_t [1:0] cfg;
  } q_entry_t;

  typedef struct packed {
    logic [7:0] blk_len;   // characters in the current block
    logic       blk_last;  // current block is the last of the line
  } line_in_t;

  typedef struct packed {
    logic       blank;
    logic [5:0] blk;
    logic [8:0] shift;     // column c shows char c + shift - DISP_W
    logic [7:0] vis_len;   // characters of the block that may show
  } line_view_t;

endpackage

// [message_priority_queue_scroller.sv]
/*
  Message presentation controller: decides preemption by priority,
  keeps a 32-entry priority queue, runs display timeouts and drives
  per-line static, block or character scrolling for a two-line display.
  Assumes requests, cancels and text-store answers come from logic on
  clk_sys; the text store returns the length of the block named by each
  line view in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module message_priority_queue_scroller #(
  parameter int unsigned TICK_CYC = msgq_pkg::TICK_CYCLES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire logic                  req_valid,
  input  wire msgq_pkg::msg_req_t    req,
  input  wire logic                  cancel_req,
  input  wire logic                  other_pending,
  input  wire msgq_pkg::line_in_t    line_in_0,
  input  wire msgq_pkg::line_in_t    line_in_1,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  output logic                       shown_valid,
  output logic [7:0]                 shown_id,
  output logic [7:0]                 shown_pri,
  output msgq_pkg::line_view_t       line_view_0,
  output msgq_pkg::line_view_t       line_view_1,
  output logic                       exec_valid,
  output logic [7:0]                 exec_id,
  output logic [3:0]                 exec_dest,
  output logic [5:0]                 q_count
);
  import msgq_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] timer;
    line_view_t view;
  } line_st_t;

  typedef struct packed {
    q_entry_t [QDEPTH-1:0]   q;
    logic [5:0]              count;
    logic                    shown;      // entry 0 is on the display
    logic                    queue_en;
    logic                    cancel_pend;
    logic                    restarted;
    logic [TICK_CNT_W-1:0]   tick_cnt;
    logic                    tick;
    line_st_t [1:0]          ln;
    logic [7:0]              shown_pri;
    logic                    exec_v;
    logic [7:0]              exec_id;
    logic [3:0]              exec_dest;
    logic [31:0]             rdata;
  } st_t;

  st_t        st_q;
  st_t        st_d;
  logic [7:0] req_pri;
  line_in_t   lin [2];

  // unconfigured priority counts as the default
  assign req_pri = (req.pri == PRI_NONE) ? PRI_DEFAULT : req.pri; // RQ9 RQ10
  assign lin[0]  = line_in_0;
  assign lin[1]  = line_in_1;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    q_entry_t [QDEPTH-1:0] cur;
    q_entry_t              ne;
    logic [5:0]            p;
    logic                  do_ins;
    logic                  restart;
    logic                  expire;
    logic                  step;
    logic [7:0]            ivl;
    line_cfg_t             c;
    st_d    = st_q;
    cur     = st_q.q;
    ne      = '0;
    p       = st_q.count;
    do_ins  = 1'b0;
    restart = 1'b0;
    expire  = 1'b0;
    step    = 1'b0;
    ivl     = 8'h00;
    c       = '0;

    // free-running pacing tick
    st_d.tick = 1'b0;
    if (st_q.tick_cnt == TICK_CNT_W'(TICK_CYC - 1)) begin
      st_d.tick_cnt = '0;
      st_d.tick     = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 1'b1;
    end

    // register writes and one-cycle-late reads
    if (reg_wr && reg_addr == REG_CTRL) begin
      st_d.queue_en = reg_wdata[CTRL_QEN];
    end
    st_d.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL:   st_d.rdata = {31'h0, st_q.queue_en};
        REG_STATUS: st_d.rdata = {24'h0, st_q.cancel_pend, st_q.shown,
                                  st_q.count};
        REG_SHOWN:  st_d.rdata = {16'h0, st_q.shown_pri, st_q.q[0].id};
        default:    st_d.rdata = '0;
      endcase
    end

    // timeout of the shown message only; others stay frozen
    if (st_q.shown && st_q.q[0].tmo_on && st_q.tick) begin // RQ20
      if (st_q.q[0].tmo <= 16'h0001) begin
        expire = 1'b1;                                     // RQ21
      end else begin
        cur[0].tmo = st_q.q[0].tmo - 16'h0001;             // RQ20
      end
    end
    st_d.q = cur;

    // cancel requests are sticky; a new one wins over the clear
    st_d.cancel_pend = st_q.cancel_pend | cancel_req;
    st_d.exec_v      = 1'b0;

    if (req_valid) begin
      // non-display destinations run now and leave no entry
      st_d.exec_v    = req.to_mirror | req.to_xmit | req.to_cmd; // RQ18
      st_d.exec_id   = req.id;
      st_d.exec_dest = {req.to_disp, req.to_mirror, req.to_xmit,
                        req.to_cmd};
      if (req.to_disp) begin
        ne.id         = req.id;
        ne.pri        = req_pri;
        ne.queue_flag = req.queue_flag;
        ne.tmo_on     = req.tmo_on;
        ne.tmo        = req.tmo;
        ne.cfg        = req.cfg;                           // RQ1
        // head of its priority group
        for (int i = QDEPTH - 1; i >= 0; i--) begin
          if (6'(i) < st_q.count && cur[i].pri >= req_pri) begin
            p = 6'(i);                                     // RQ12
          end
        end
        if (st_q.shown && req_pri <= st_q.q[0].pri) begin  // RQ11
          restart    = 1'b1;
          st_d.shown = 1'b1;
          if (st_q.queue_en && st_q.q[0].queue_flag) begin
            do_ins = 1'b1;
            p      = 6'h00;
          end else begin
            st_d.q[0] = ne;                                // RQ17 RQ15
          end
        end else if (!st_q.shown && p == 6'h00) begin
          do_ins     = 1'b1;
          restart    = 1'b1;
          st_d.shown = 1'b1;
        end else if (st_q.queue_en && req.queue_flag) begin
          do_ins = 1'b1;                                   // RQ16 RQ11
        end
      end
    end else if (st_q.cancel_pend) begin
      st_d.cancel_pend = cancel_req;
      if (st_q.shown) begin
        for (int i = 0; i < QDEPTH - 1; i++) begin
          st_d.q[i] = cur[i+1];                            // RQ19
        end
        st_d.q[QDEPTH-1] = '0;
        st_d.count       = st_q.count - 6'h01;
        st_d.shown       = 1'b0;
      end
    end else if (!st_q.shown && st_q.count != 6'h00 && !other_pending) begin
      st_d.shown = 1'b1;                                   // RQ13
      restart    = 1'b1;
    end

    // expiry only cancels the message that stays on the display
    if (expire && st_d.shown && !restart) begin
      st_d.cancel_pend = 1'b1;                             // RQ21
    end

    // insertion; full queue loses its bottom or refuses a last newcomer
    if (do_ins && p < QDEPTH_CNT) begin                    // RQ22 RQ14
      for (int i = QDEPTH - 1; i > 0; i--) begin
        if (6'(i) > p) begin
          st_d.q[i] = cur[i-1];
        end
      end
      st_d.q[p[4:0]] = ne;                                 // RQ12
      if (st_q.count < QDEPTH_CNT) begin
        st_d.count = st_q.count + 6'h01;
      end
    end

    st_d.restarted = restart;
    st_d.shown_pri = st_d.shown ? st_d.q[0].pri : PRI_NONE;

    // per-line scrolling of the shown message
    for (int l = 0; l < 2; l++) begin
      c   = st_d.q[0].cfg[l];                              // RQ1
      ivl = (c.mode == SCR_CHAR) ? c.chr_time : c.blk_time;
      if (ivl == 8'h00) begin
        ivl = 8'h01;
      end
      if (c.mode == SCR_CHAR) begin
        st_d.ln[l].view.vis_len = lin[l].blk_len;
      end else if ({1'b0, lin[l].blk_len} > DISP_W) begin
        st_d.ln[l].view.vis_len = DISP_W[7:0];             // RQ5
      end else begin
        st_d.ln[l].view.vis_len = lin[l].blk_len;
      end
      if (restart || !st_d.shown) begin
        st_d.ln[l].timer      = 8'h00;
        st_d.ln[l].view.blank = !st_d.shown;
        st_d.ln[l].view.blk   = 6'h00;
        st_d.ln[l].view.shift = (c.mode == SCR_CHAR) ? 9'h000 : DISP_W;
      end else if (st_q.tick && c.mode != SCR_STATIC) begin // RQ2
        step = (st_q.ln[l].timer + 8'h01) >= ivl;
        st_d.ln[l].timer = step ? 8'h00 : st_q.ln[l].timer + 8'h01;
        if (step && c.mode == SCR_BLOCK) begin
          if (st_q.ln[l].view.blank) begin
            st_d.ln[l].view.blank = 1'b0;                  // RQ4
            st_d.ln[l].view.blk   = 6'h00;
          end else if (lin[l].blk_last) begin
            st_d.ln[l].view.blank = 1'b1;                  // RQ4
          end else begin
            st_d.ln[l].view.blk = st_q.ln[l].view.blk + 6'h01; // RQ3
          end
        end else if (step) begin
          if (st_q.ln[l].view.shift >=
              {1'b0, lin[l].blk_len} + DISP_W - 9'h001) begin
            st_d.ln[l].view.shift = 9'h000;                // RQ7
            st_d.ln[l].view.blk   = lin[l].blk_last ? 6'h00 :
                                    st_q.ln[l].view.blk + 6'h01; // RQ8
          end else begin
            st_d.ln[l].view.shift = st_q.ln[l].view.shift + 9'h001; // RQ6
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q          <= '0;
      st_q.queue_en <= QEN_RST;
      st_q.ln[0].view.blank <= 1'b1;
      st_q.ln[1].view.blank <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state flip-flops
  assign reg_rdata   = st_q.rdata;
  assign shown_valid = st_q.shown;
  assign shown_id    = st_q.q[0].id;
  assign shown_pri   = st_q.shown_pri;
  assign line_view_0 = st_q.ln[0].view;
  assign line_view_1 = st_q.ln[1].view;
  assign exec_valid  = st_q.exec_v;
  assign exec_id     = st_q.exec_id;
  assign exec_dest   = st_q.exec_dest;
  assign q_count     = st_q.count;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic sorted_ok;

  // neighbours in the occupied part stay in priority order
  always_comb begin
    sorted_ok = 1'b1;
    for (int i = 0; i < QDEPTH - 1; i++) begin
      if (6'(i + 1) < st_q.count && st_q.q[i].pri > st_q.q[i+1].pri) begin
        sorted_ok = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_disp_req;
    req_valid && req.to_disp && shown_valid;
  endsequence

  sequence s_cancel_taken;
    !req_valid && st_q.cancel_pend && shown_valid;
  endsequence

  sequence s_idle_waiting;
    !req_valid && !st_q.cancel_pend && !shown_valid &&
    q_count != 6'h00 && !other_pending;
  endsequence

  a_preempt_equal: assert property ( // RQ11
    s_disp_req and (req_pri <= shown_pri) |=>
      shown_valid && shown_id == $past(req.id))
    else $error("equal or better request did not take the display");

  a_lower_keeps: assert property ( // RQ11
    s_disp_req and (req_pri > shown_pri) |=>
      shown_valid && $stable(shown_id))
    else $error("less important request displaced the shown message");

  a_exec_no_entry: assert property ( // RQ18
    req_valid && !req.to_disp && (req.to_cmd || req.to_xmit) |=>
      exec_valid && $stable(q_count))
    else $error("non-display message was queued or not executed");

  a_cancel_shift: assert property ( // RQ19
    s_cancel_taken |=> !shown_valid &&
      q_count == 6'($past(q_count) - 6'h01))
    else $error("cancel did not remove exactly one entry");

  a_promote_top: assert property ( // RQ13
    s_idle_waiting |=> shown_valid && shown_id == $past(shown_id))
    else $error("top entry not placed on the display");

  a_pri_valid: assert property ( // RQ10
    shown_valid |-> shown_pri != PRI_NONE)
    else $error("shown message carries priority zero");

  a_queue_order: assert property ( // RQ12
    sorted_ok)
    else $error("queue entries out of priority order");

  a_queue_bound: assert property ( // RQ14
    q_count <= QDEPTH_CNT)
    else $error("queue holds more than its depth");

  a_char_step: assert property ( // RQ6
    shown_valid && !st_q.restarted &&
    line_view_1.shift != $past(line_view_1.shift) |->
      line_view_1.shift == 9'($past(line_view_1.shift) + 9'h001) ||
      line_view_1.shift == 9'h000)
    else $error("character scroll moved by more than one position");

  // an expiring shown message is marked for cancel
  a_expire_cancel: assert property ( // RQ21
    shown_valid && st_q.tick && st_q.q[0].tmo_on && !st_q.cancel_pend &&
    st_q.q[0].tmo <= 16'h0001 && !req_valid |=> st_q.cancel_pend)
    else $error("expired message was not marked for cancel");

  // the entry waiting below the shown one keeps its remaining time
  a_frozen_tmo: assert property ( // RQ20
    shown_valid && !req_valid && !st_q.cancel_pend |=>
      st_q.q[1].tmo == $past(st_q.q[1].tmo))
    else $error("waiting entry lost its remaining time");

  // line 0, when static, never moves while its message stays shown
  a_static_fixed: assert property ( // RQ2
    shown_valid && !st_q.restarted &&
    st_q.q[0].cfg[0].mode == SCR_STATIC |->
      line_view_0.shift == DISP_W && $stable(line_view_0.blk))
    else $error("static line moved");

  // scroll positions move only on a pacing tick
  a_tick_paced: assert property ( // RQ3
    shown_valid && !st_q.tick && !req_valid && !st_q.cancel_pend |=>
      $stable(line_view_0.blk) && $stable(line_view_1.shift))
    else $error("scroll position moved between ticks");

endmodule

`default_nettype wire

// [text_store_model.sv]
/*
  Text store stand-in for the scroller: answers block length and
  last-block flag for the block each line view names.
  Assumes line views are registered on clk_sys; answers are immediate.
*/
`timescale 1ns/1ps
`default_nettype none

module text_store_model
  import msgq_pkg::*;
(
  input  wire msgq_pkg::line_view_t view_0,
  input  wire msgq_pkg::line_view_t view_1,
  output var  msgq_pkg::line_in_t   ans_0,
  output var  msgq_pkg::line_in_t   ans_1
);
  // ------------------------------------------------------------------
  // block table
  // ------------------------------------------------------------------
  // lengths 5, 25, 8; block 1 is wider than the line on purpose
  function automatic line_in_t look(input logic [5:0] b);
    line_in_t r;
    r.blk_last = (b >= 6'h02);
    r.blk_len  = (b == 6'h00) ? 8'h05 : (b == 6'h01) ? 8'h19 : 8'h08;
    return r;
  endfunction

  // both lines share one text layout
  assign ans_0 = look(view_0.blk);
  assign ans_1 = look(view_1.blk);
endmodule

`default_nettype wire

// [test_message_priority_queue_scroller.sv]
/*
  Self-checking bench of the message queue and scroller.
  Assumes msgq_pkg and the text store stand-in are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); \
  end \
end

module test_message_priority_queue_scroller;
  import msgq_pkg::*;
  // ------------------------------------------------------------------
  // stimulus and wiring
  // ------------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        req_valid = 1'b0;
  msg_req_t    req = '0;
  logic        cancel_req = 1'b0;
  logic        other_pending = 1'b0;
  line_in_t    line_in_0;
  line_in_t    line_in_1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        shown_valid;
  logic [7:0]  shown_id;
  logic [7:0]  shown_pri;
  line_view_t  line_view_0;
  line_view_t  line_view_1;
  logic        exec_valid;
  logic [7:0]  exec_id;
  logic [3:0]  exec_dest;
  logic [5:0]  q_count;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  message_priority_queue_scroller #(.TICK_CYC(4)) u_dut (
    .clk_sys(clk_sys), .srst(srst), .req_valid(req_valid), .req(req),
    .cancel_req(cancel_req), .other_pending(other_pending),
    .line_in_0(line_in_0), .line_in_1(line_in_1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .shown_valid(shown_valid),
    .shown_id(shown_id), .shown_pri(shown_pri),
    .line_view_0(line_view_0), .line_view_1(line_view_1),
    .exec_valid(exec_valid), .exec_id(exec_id), .exec_dest(exec_dest),
    .q_count(q_count)
  );

  text_store_model u_store (
    .view_0(line_view_0), .view_1(line_view_1),
    .ans_0(line_in_0), .ans_1(line_in_1)
  );

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic msg_req_t mk(input logic [7:0] id,
                                  input logic [7:0] pri, input logic fl);
    msg_req_t m;
    m = '0;
    m.id = id;
    m.pri = pri;
    m.to_disp = 1'b1;
    m.queue_flag = fl;
    return m;
  endfunction

  task automatic send(input msg_req_t m);
    @(posedge clk_sys);
    req <= m;
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    #1;
  endtask

  task automatic cancel_shown(input logic op);
    @(posedge clk_sys);
    cancel_req <= 1'b1;
    other_pending <= op;
    @(posedge clk_sys);
    cancel_req <= 1'b0;
    tick(4);
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // cycles until line 0 leaves its present block state
  task automatic dwell(output int n);
    logic [6:0] s;
    s = {line_view_0.blank, line_view_0.blk};
    n = 0;
    while ({line_view_0.blank, line_view_0.blk} === s && n < 100) begin
      tick(1);
      n++;
    end
  endtask

  // cycles until line 1 shifts again
  task automatic step(output int n);
    logic [8:0] s;
    s = line_view_1.shift;
    n = 0;
    while (line_view_1.shift === s && n < 50) begin
      tick(1);
      n++;
    end
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    `CHK(shown_valid, 1'b0)
    `CHK(q_count, 6'h00)
    `CHK(line_view_0.blank, 1'b1)
    reg_read(REG_CTRL, d);
    `CHK(d, 32'h00000001)
    reg_read(4'hC, d);
    `CHK(d, 32'h00000000)
  endtask

  task automatic t_prio;
    send(mk(8'h01, 8'h05, 1'b1));
    send(mk(8'h02, 8'h05, 1'b1));
    send(mk(8'h03, 8'h09, 1'b1));
    send(mk(8'h04, 8'h09, 1'b0));
    tick(2);
    `CHK(shown_id, 8'h02)
    `CHK(q_count, 6'h03)
    `CHK(line_view_0.shift, 9'h014)
    cancel_shown(1'b0);
    `CHK(shown_id, 8'h01)
    `CHK(q_count, 6'h02)
    cancel_shown(1'b1);
    `CHK(shown_valid, 1'b0)
    `CHK(q_count, 6'h01)
    @(posedge clk_sys);
    other_pending <= 1'b0;
    tick(4);
    `CHK(shown_id, 8'h03)
    send(mk(8'h05, 8'h00, 1'b0));
    tick(1);
    `CHK(shown_pri, 8'h01)
    `CHK(q_count, 6'h02)
    cancel_shown(1'b0);
    `CHK(shown_id, 8'h03)
    `CHK(q_count, 6'h01)
    cancel_shown(1'b0);
    `CHK(q_count, 6'h00)
  endtask

  task automatic t_exec;
    msg_req_t m;
    for (int i = 0; i < 3; i++) begin
      m = mk(8'h20 + 8'(i), 8'h00, 1'b0);
      m.to_disp = 1'b0;
      m.to_mirror = (i == 0);
      m.to_xmit = (i == 1);
      m.to_cmd = (i == 2);
      send(m);
      `CHK(exec_valid, 1'b1)
      `CHK(exec_dest, 4'h4 >> i)
      `CHK(exec_id, m.id)
      tick(1);
      `CHK(exec_valid, 1'b0)
      `CHK(q_count, 6'h00)
    end
  endtask

  task automatic t_timeout;
    msg_req_t m;
    int n;
    m = mk(8'h07, 8'h01, 1'b0);
    m.tmo_on = 1'b1;
    m.tmo = 16'h0003;
    send(m);
    `CHK(shown_id, 8'h07)
    n = 0;
    while (shown_valid === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    `CHK(n >= 8 && n <= 20, 1'b1)
  endtask

  task automatic t_scroll;
    msg_req_t m;
    int n;
    logic [8:0] sh;
    m = mk(8'h08, 8'h01, 1'b0);
    m.cfg[0].mode = SCR_BLOCK;
    m.cfg[0].blk_time = 8'h02;
    m.cfg[1].mode = SCR_CHAR;
    m.cfg[1].chr_time = 8'h01;
    send(m);
    n = 0;
    while (line_view_0.blk !== 6'h01 && n < 100) begin
      tick(1);
      n++;
    end
    // vis_len trails blk by one cycle
    tick(1);
    `CHK(line_view_0.vis_len, 8'h14)
    dwell(n);
    `CHK(n, 7)
    `CHK(line_view_0.blk, 6'h02)
    tick(1);
    `CHK(line_view_0.vis_len, 8'h08)
    dwell(n);
    `CHK(n, 7)
    `CHK(line_view_0.blank, 1'b1)
    dwell(n);
    `CHK(n, 8)
    `CHK(line_view_0.blk, 6'h00)
    step(n);
    sh = line_view_1.shift;
    step(n);
    `CHK(n, 4)
    `CHK(line_view_1.shift, sh + 9'h001)
    // first block leaves on the left, next block enters from the right
    n = 0;
    while (line_view_1.shift !== 9'h000 && n < 200) begin
      tick(1);
      n++;
    end
    `CHK(line_view_1.blk, 6'h01)
    `CHK(n < 200, 1'b1)
    cancel_shown(1'b0);
  endtask

  task automatic t_qoff;
    logic [31:0] d;
    reg_write(REG_CTRL, 32'h0);
    reg_read(REG_CTRL, d);
    `CHK(d, 32'h00000000)
    send(mk(8'h28, 8'h01, 1'b1));
    send(mk(8'h29, 8'h09, 1'b1));
    tick(1);
    `CHK(q_count, 6'h01)
    `CHK(shown_id, 8'h28)
    cancel_shown(1'b0);
    `CHK(q_count, 6'h00)
    reg_write(REG_CTRL, 32'h1);
  endtask

  task automatic t_full;
    logic [31:0] d;
    send(mk(8'h64, 8'h01, 1'b1));
    for (int i = 0; i < 31; i++) begin
      send(mk(8'(i), 8'h02, 1'b1));
    end
    tick(1);
    `CHK(q_count, 6'h20)
    send(mk(8'hC8, 8'hC8, 1'b1));
    send(mk(8'hC9, 8'h02, 1'b1));
    reg_read(REG_STATUS, d);
    `CHK(d[7:0], 8'h60)
    cancel_shown(1'b0);
    `CHK(shown_id, 8'hC9)
    `CHK(q_count, 6'h1F)
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    tick(1);
    t_reset;
    t_prio;
    t_exec;
    t_timeout;
    t_scroll;
    t_qoff;
    t_full;
    report_and_stop;
  end
endmodule

`default_nettype wire
